// ---- rtl/asp_ctrl.sv ----
// Asynchronous SRAM expansion port access sequencer.
// Assumes a core-side request port and external tristate glue fed by data_oe.
//
// What this block does
// - Read strobe low only during an external read access.
// - Store strobe low only during an external write access.
// - 18-bit address output, changes only on accesses, otherwise held.
// - 24-bit data bus used only on accesses, otherwise keeps state.
// - Four region selects act as chip selects decoded from the top address bits.
// - Row-strobe option turns region pins into DRAM row strobes.
// - All strobe timing counted in core cycles, one cycle per wait.
// - Read and write windows grow by one cycle per extra wait state.
// - Read target is address bus plus region selects at access start.
// - Read strobe asserted a setup delay after address valid.
// - Capture data, then release read strobe; no hold needed.
// - Write drives address and regions, then store strobe after setup.
// - Write data driven within bounded delay of store strobe.
// - Write data stable a setup interval before store strobe release.
// - Address, regions and data held a while after store strobe rises.
// - At least one wait state inserted on every access.
// - Wait count per region, with a default outside all regions.
// - Region select asserted on an address and space match; reset loads 0, which asserts active-low selects and row strobes.
`timescale 1ns/1ps
module asp_ctrl #(
    parameter int ADDR_W = asp_pkg::ADDR_W,
    parameter int DATA_W = asp_pkg::DATA_W,
    parameter int REGIONS = asp_pkg::REGIONS,
    parameter int WAIT_W = asp_pkg::WAIT_W,
    parameter int CMP_W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Core request
    input wire logic req,
    input wire logic req_write,
    input wire logic [1:0] req_space,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // Configuration levels
    input wire logic row_strobe_mode,
    input wire logic [REGIONS*WAIT_W-1:0] region_wait,
    input wire logic [WAIT_W-1:0] default_wait,
    input wire logic [REGIONS*3-1:0] region_spaces,
    input wire logic [REGIONS*CMP_W-1:0] region_match,
    input wire logic [REGIONS-1:0] region_active_low,
    // External pins
    output logic read_strobe_n,
    output logic store_strobe_n,
    output logic [ADDR_W-1:0] ext_address_bus,
    output logic [REGIONS-1:0] region_select,
    output logic [DATA_W-1:0] ext_data_out,
    output logic data_oe,
    input wire logic [DATA_W-1:0] ext_data_in
);
    // ************************************************
    // Region decode
    // ************************************************
    logic [REGIONS-1:0] hit;
    logic [WAIT_W-1:0] sel_wait;
    genvar g;
    generate
        for (g = 0; g < REGIONS; g++) begin : g_region
            // Compare the top address bits and the memory space
            assign hit[g] = region_spaces[g*3 + req_space] &&
                (req_space != 2'h3) &&
                (req_addr[ADDR_W-1 -: CMP_W] == region_match[g*CMP_W +: CMP_W]);
        end
    endgenerate

    always_comb begin
        sel_wait = default_wait;
        for (int i = REGIONS - 1; i >= 0; i--) begin
            // Lowest numbered region wins when several overlap
            if (hit[i]) begin
                sel_wait = region_wait[i*WAIT_W +: WAIT_W];
            end
        end
        // Every access gets at least MIN_WAIT wait states, even from a zero entry
        if (sel_wait < asp_pkg::MIN_WAIT) begin
            sel_wait = asp_pkg::MIN_WAIT;
        end
    end

    // ************************************************
    // Access sequencer
    // ************************************************
    asp_pkg::asp_state_t state, next_state;
    logic [WAIT_W-1:0] cnt, next_cnt;
    logic wr, next_wr;
    logic next_busy, next_done, next_rs_n, next_ss_n, next_oe;
    logic [DATA_W-1:0] next_rdata, next_dout;
    logic [ADDR_W-1:0] next_addr;
    logic [REGIONS-1:0] next_region;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wr = wr;
        next_busy = busy;
        next_done = 1'b0;
        next_rs_n = 1'b1;
        next_ss_n = 1'b1;
        next_oe = data_oe;
        next_rdata = rdata;
        next_dout = ext_data_out;
        next_addr = ext_address_bus;
        next_region = region_select;
        case (state)
            asp_pkg::ASP_IDLE: begin
                next_oe = 1'b0;
                if (req) begin
                    next_state = asp_pkg::ASP_SETUP;
                    next_wr = req_write;
                    next_busy = 1'b1;
                    next_addr = req_addr;
                    // Row strobes are active low; attributes follow the polarity setting
                    if (row_strobe_mode) begin
                        next_region = ~hit;
                    end else begin
                        next_region = hit ^ region_active_low;
                    end
                    next_cnt = asp_pkg::ADDR_SETUP_CYC[WAIT_W-1:0] - 5'h01;
                end
            end
            asp_pkg::ASP_SETUP: begin
                if (cnt == '0) begin
                    next_state = asp_pkg::ASP_STROBE;
                    next_cnt = sel_wait - 5'h01;
                    next_rs_n = wr;
                    next_ss_n = ~wr;
                    if (wr) begin
                        next_oe = 1'b1;
                        next_dout = req_wdata;
                    end
                end else begin
                    next_cnt = cnt - 5'h01;
                end
            end
            asp_pkg::ASP_STROBE: begin
                next_rs_n = wr;
                next_ss_n = ~wr;
                if (cnt == '0) begin
                    next_state = asp_pkg::ASP_RELEASE;
                    next_rs_n = 1'b1;
                    next_ss_n = 1'b1;
                    if (!wr) begin
                        next_rdata = ext_data_in;
                    end
                    next_cnt = asp_pkg::HOLD_CYC[WAIT_W-1:0] - 5'h01;
                end else begin
                    next_cnt = cnt - 5'h01;
                end
            end
            asp_pkg::ASP_RELEASE: begin
                // Address, regions and data stay put through the hold
                if (cnt == '0) begin
                    next_state = asp_pkg::ASP_HOLD;
                end else begin
                    next_cnt = cnt - 5'h01;
                end
            end
            asp_pkg::ASP_HOLD: begin
                next_state = asp_pkg::ASP_IDLE;
                next_oe = 1'b0;
                next_busy = 1'b0;
                next_done = 1'b1;
                // Regions go inactive; address bus keeps its last value
                next_region = row_strobe_mode ? {REGIONS{1'b1}} : region_active_low;
            end
            default: begin
                next_state = asp_pkg::ASP_IDLE;
                next_busy = 1'b0;
                next_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= asp_pkg::ASP_IDLE;
            cnt <= '0;
            wr <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            read_strobe_n <= 1'b1;
            store_strobe_n <= 1'b1;
            data_oe <= 1'b0;
            rdata <= asp_pkg::DATA_RST;
            ext_data_out <= asp_pkg::DATA_RST;
            ext_address_bus <= asp_pkg::ADDR_RST;
            region_select <= asp_pkg::REGION_RST;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
            wr <= next_wr;
            busy <= next_busy;
            done <= next_done;
            read_strobe_n <= next_rs_n;
            store_strobe_n <= next_ss_n;
            data_oe <= next_oe;
            rdata <= next_rdata;
            ext_data_out <= next_dout;
            ext_address_bus <= next_addr;
            region_select <= next_region;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_no_both_strobes;
        @(posedge clk) disable iff (rst) !(!read_strobe_n && !store_strobe_n);
    endproperty
    a_no_both_strobes: assert property (p_no_both_strobes) else $error("both strobes low");

    property p_oe_only_write;
        @(posedge clk) disable iff (rst) data_oe |-> wr && busy;
    endproperty
    a_oe_only_write: assert property (p_oe_only_write) else $error("data driven off write");

    property p_read_strobe_in_read;
        @(posedge clk) disable iff (rst) !read_strobe_n |-> busy && !wr;
    endproperty
    a_read_strobe_in_read: assert property (p_read_strobe_in_read) else $error("read strobe");

    property p_store_strobe_in_write;
        @(posedge clk) disable iff (rst) !store_strobe_n |-> busy && wr && data_oe;
    endproperty
    a_store_strobe_in_write: assert property (p_store_strobe_in_write) else $error("store");

    property p_addr_stable_idle;
        @(posedge clk) disable iff (rst) (!busy && $past(!busy)) |-> $stable(ext_address_bus);
    endproperty
    a_addr_stable_idle: assert property (p_addr_stable_idle) else $error("address moved");

    property p_strobe_after_setup;
        @(posedge clk) disable iff (rst || !ce)
            $fell(read_strobe_n) || $fell(store_strobe_n) |-> $past(state) == asp_pkg::ASP_SETUP;
    endproperty
    a_strobe_after_setup: assert property (p_strobe_after_setup) else $error("no setup");

    property p_min_wait;
        @(posedge clk) disable iff (rst || !ce)
            $rose(read_strobe_n) || $rose(store_strobe_n) |-> $past(state) == asp_pkg::ASP_STROBE;
    endproperty
    a_min_wait: assert property (p_min_wait) else $error("strobe too short");

    property p_hold_after_store;
        @(posedge clk) disable iff (rst || !ce)
            $rose(store_strobe_n) |-> data_oe && $stable(ext_address_bus) && $stable(ext_data_out);
    endproperty
    a_hold_after_store: assert property (p_hold_after_store) else $error("hold lost");

    property p_done_pulse;
        @(posedge clk) disable iff (rst || !ce) done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

    property p_strobe_len;
        @(posedge clk) disable iff (rst || !ce)
            $fell(read_strobe_n) || $fell(store_strobe_n) |-> cnt == $past(sel_wait) - 5'h01;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe count wrong");

    property p_capture_read;
        @(posedge clk) disable iff (rst || !ce)
            $rose(read_strobe_n) |-> rdata == $past(ext_data_in);
    endproperty
    a_capture_read: assert property (p_capture_read) else $error("read not captured");

    property p_addr_at_start;
        @(posedge clk) disable iff (rst || !ce)
            $changed(ext_address_bus) |-> busy && $past(state) == asp_pkg::ASP_IDLE;
    endproperty
    a_addr_at_start: assert property (p_addr_at_start) else $error("address moved");

    property p_regions_stable;
        @(posedge clk) disable iff (rst || !ce)
            busy && $past(busy) |-> $stable(region_select);
    endproperty
    a_regions_stable: assert property (p_regions_stable) else $error("region moved");

    property p_addr_before_strobe;
        @(posedge clk) disable iff (rst || !ce)
            $fell(read_strobe_n) || $fell(store_strobe_n) |-> $stable(ext_address_bus);
    endproperty
    a_addr_before_strobe: assert property (p_addr_before_strobe) else $error("no setup");

    property p_data_with_store;
        @(posedge clk) disable iff (rst || !ce)
            $fell(store_strobe_n) |-> data_oe;
    endproperty
    a_data_with_store: assert property (p_data_with_store) else $error("data late");

    property p_busy_state;
        @(posedge clk) disable iff (rst || !ce) busy |-> state != asp_pkg::ASP_IDLE;
    endproperty
    a_busy_state: assert property (p_busy_state) else $error("busy while idle");
endmodule

// ---- rtl/asp_pkg.sv ----
// Constants of the asynchronous SRAM expansion port controller.
// Assumes one 25 MHz core clock, with every strobe time counted in its cycles.
package asp_pkg;
    // ************************************************
    // Widths and timing
    // ************************************************
    localparam int ADDR_W = 18;
    localparam int DATA_W = 24;
    localparam int REGIONS = 4;
    localparam int WAIT_W = 5;
    localparam int CLK_PERIOD_PS = 40000;
    // Setup of address before a strobe, a least time in ps
    localparam int ADDR_SETUP_PS = 1;
    localparam int ADDR_SETUP_CYC = (ADDR_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Address and write data held after the store strobe rises
    localparam int HOLD_PS = 1;
    localparam int HOLD_CYC = (HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [4:0] MIN_WAIT = 5'h01;
    localparam logic [17:0] ADDR_RST = 18'h00000;
    localparam logic [23:0] DATA_RST = 24'h000000;
    localparam logic [3:0] REGION_RST = 4'h0;
    // Per-region attribute: memory space enables
    localparam int SPACE_P = 0;
    localparam int SPACE_X = 1;
    localparam int SPACE_Y = 2;

    typedef enum logic [4:0] {
        ASP_IDLE = 5'h01,
        ASP_SETUP = 5'h02,
        ASP_STROBE = 5'h04,
        ASP_RELEASE = 5'h08,
        ASP_HOLD = 5'h10
    } asp_state_t;
endpackage

// ---- sim/asp_sram_model.sv ----
// Behavioural asynchronous static RAM on the far side of the expansion port.
// Assumes the port drives active-low strobes and keeps address stable during a strobe.
`timescale 1ns/1ps
module asp_sram_model #(
    parameter int ACC_NS = 10
) (
    input wire logic read_strobe_n,
    input wire logic store_strobe_n,
    input wire logic [17:0] addr,
    input wire logic [23:0] wdata,
    output logic [23:0] rdata
);
    // ************************************************
    // Storage and answer
    // ************************************************
    logic [23:0] mem [logic [17:0]];
    logic [23:0] last = 24'h5a5a5a;
    // Write lands at strobe release, so the whole granted window is used
    always @(posedge store_strobe_n) mem[addr] = wdata;
    // Access time below one core cycle, well inside any granted window
    initial begin
        rdata = 24'ha5a5a5;
        forever begin
            @(negedge read_strobe_n);
            #ACC_NS;
            if (!read_strobe_n) begin
                rdata = mem.exists(addr) ? mem[addr] : 24'h000000;
                last = rdata;
            end
            @(posedge read_strobe_n);
            // Released lines show no stale copy of the data
            rdata = ~last;
        end
    end
endmodule

// ---- sim/async_sram_port_access_bench.sv ----
// Self-checking bench of the expansion port access sequencer.
// Assumes the sequencer and the static RAM model of this folder.
`timescale 1ns/1ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: %s", $time, m); end end
module async_sram_port_access_bench;
    // ************************************************
    // Stimulus and wiring
    // ************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0, req_write = 1'b0, row_strobe_mode = 1'b0;
    logic ce = 1'b1;
    logic [3:0] region_active_low = 4'hf;
    // Cycles with the clock enable low right after a take
    int freeze = 0;
    logic [1:0] req_space = 2'h0;
    logic [17:0] req_addr = 18'h00000;
    logic [23:0] req_wdata = 24'h000000;
    logic [19:0] region_wait = {5'h00, 5'h00, 5'h04, 5'h02};
    logic [4:0] default_wait = 5'h03;
    logic [11:0] region_spaces = {3'h0, 3'h0, 3'h2, 3'h1};
    logic [15:0] region_match = {4'hf, 4'hf, 4'h2, 4'h1};
    logic busy, done, read_strobe_n, store_strobe_n, data_oe;
    logic [23:0] rdata, ext_data_out, ext_data_in;
    logic [17:0] ext_address_bus;
    logic [3:0] region_select;
    int err_total = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    asp_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .req_write(req_write),
        .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
        .done(done), .rdata(rdata), .row_strobe_mode(row_strobe_mode),
        .region_wait(region_wait), .default_wait(default_wait),
        .region_spaces(region_spaces), .region_match(region_match),
        .region_active_low(region_active_low), .read_strobe_n(read_strobe_n),
        .store_strobe_n(store_strobe_n), .ext_address_bus(ext_address_bus),
        .region_select(region_select), .ext_data_out(ext_data_out), .data_oe(data_oe),
        .ext_data_in(ext_data_in));
    asp_sram_model mem_model (.read_strobe_n(read_strobe_n), .store_strobe_n(store_strobe_n),
        .addr(ext_address_bus), .wdata(ext_data_out), .rdata(ext_data_in));
    // ************************************************
    // Shared access with per-cycle watching
    // ************************************************
    task automatic xfer(input logic wr, input logic [1:0] sp, input logic [17:0] a,
        input logic [23:0] d, input int w, input logic [3:0] hit);
        int n, rl, sl;
        logic bad;
        n = 0;
        rl = 0;
        sl = 0;
        bad = 1'b0;
        @(negedge clk);
        req = 1'b1;
        req_write = wr;
        req_space = sp;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req = 1'b0;
        `CHK(busy, 1'b1, "busy after take")
        // A frozen sequencer must not advance, so the latency below stays the same
        if (freeze > 0) begin
            ce = 1'b0;
            repeat (freeze) @(negedge clk);
            ce = 1'b1;
        end
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
            if (read_strobe_n === 1'b0) rl++;
            if (store_strobe_n === 1'b0) sl++;
            if ((read_strobe_n | store_strobe_n) !== 1'b1) bad = 1'b1;
            if (!wr && data_oe !== 1'b0) bad = 1'b1;
            if ((read_strobe_n & store_strobe_n) === 1'b0 &&
                (region_select !== hit || ext_address_bus !== a)) bad = 1'b1;
            if (store_strobe_n === 1'b0 && (data_oe !== 1'b1 || ext_data_out !== d))
                bad = 1'b1;
        end
        if (done !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: access timed out", $time);
            wrap_up();
        end
        `CHK(n, asp_pkg::ADDR_SETUP_CYC + w + asp_pkg::HOLD_CYC + 1, "done latency")
        `CHK(busy, 1'b0, "busy at done")
        `CHK(rl, wr ? 0 : w, "read strobe length")
        `CHK(sl, wr ? w : 0, "store strobe length")
        `CHK(bad, 1'b0, "pins during strobe")
        if (!wr) `CHK(rdata, d, "read data")
        @(negedge clk);
        `CHK(ext_address_bus, a, "address held")
        `CHK({data_oe, region_select}, {1'b0, row_strobe_mode ? 4'hf : region_active_low},
            "idle pins")
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset();
        `CHK({read_strobe_n, store_strobe_n, data_oe}, 3'h6, "reset pins")
    endtask
    task automatic t_region_zero();
        xfer(1'b1, 2'h0, 18'h04005, 24'h123456, 2, 4'he);
        xfer(1'b0, 2'h0, 18'h04005, 24'h123456, 2, 4'he);
    endtask
    task automatic t_other_regions();
        xfer(1'b0, 2'h1, 18'h04005, 24'h123456, 3, 4'hf);
        xfer(1'b1, 2'h1, 18'h08001, 24'hfedcba, 4, 4'hd);
        xfer(1'b0, 2'h2, 18'h08001, 24'hfedcba, 3, 4'hf);
    endtask
    task automatic t_zero_wait();
        region_wait[4:0] = 5'h00;
        xfer(1'b0, 2'h0, 18'h04005, 24'h123456, 1, 4'he);
    endtask
    task automatic t_row_strobe();
        row_strobe_mode = 1'b1;
        xfer(1'b0, 2'h1, 18'h08001, 24'hfedcba, 4, 4'hd);
    endtask
    task automatic t_freeze();
        freeze = 3;
        xfer(1'b1, 2'h0, 18'h04005, 24'h3c3c3c, 1, 4'he);
        xfer(1'b0, 2'h0, 18'h04005, 24'h3c3c3c, 1, 4'he);
        freeze = 0;
    endtask
    task automatic t_active_high();
        region_active_low = 4'h0;
        xfer(1'b0, 2'h0, 18'h04005, 24'h3c3c3c, 1, 4'h1);
        region_active_low = 4'hf;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_region_zero();
        t_other_regions();
        t_zero_wait();
        t_freeze();
        t_active_high();
        t_row_strobe();
        wrap_up();
    end
endmodule
